/* File: hw/spds_regs.vh */
// Register offsets, field positions, reset values and limits of the drop statistics block.
`ifndef SPDS_REGS_VH
`define SPDS_REGS_VH

`define SPDS_NPORTS          5
`define SPDS_NCNT            7
`define SPDS_NCNT_TOTAL      35
`define SPDS_PORT_LAST       3'h4
`define SPDS_SEL_LAST        3'h6

// Counter selector within one port; byte address = port * 0x20 + selector * 4.
`define SPDS_SEL_RX_FIFO     3'h0
`define SPDS_SEL_ZERO_MASK   3'h1
`define SPDS_SEL_SOF_OVR     3'h2
`define SPDS_SEL_RATE_LIM    3'h3
`define SPDS_SEL_VLAN_ING    3'h4
`define SPDS_SEL_DA_EQ_SA    3'h5
`define SPDS_SEL_UNKN_UNI    3'h6

`define SPDS_PORT_LSB        5
`define SPDS_PORT_MSB        7
`define SPDS_SEL_LSB         2
`define SPDS_SEL_MSB         4
`define SPDS_CNT_REGION      4'h0

`define SPDS_CTRL_OFS        12'h100
`define SPDS_STAT_OFS        12'h104

`define SPDS_CTRL_MAXLEN_MSB 13
`define SPDS_STAT_ANOM_MSB   4

`define SPDS_CNT_RST         32'h00000000
`define SPDS_MAXLEN_RST      14'h05EE
`define SPDS_STAT_RST        5'h00

`define SPDS_HOST_MIN_LEN    14'h0011
`define SPDS_SHORT_LEN       14'h0021
`define SPDS_UNI_MIN_LEN     14'h0040

`endif

/* File: hw/spds_drop_stats.v */
// Per-port drop statistics counters of a multi-port switch with an APB register slave.
//
// Overview of operation
// - Receive FIFO overrun counter counts every frame dropped for lack of FIFO space.
// - Ethernet ports drop at receive FIFO only with flow control on and pause ignored.
// - Host port also counts dropped frames of 17 to 32 bytes.
// - Ethernet port drops below 33 bytes belong to fragment counters, not here.
// - No statistic here updates for frames shorter than 33 bytes, except above.
// - Zero forward mask drops count for data or control frames above 32 bytes.
// - Zero mask drops may double count elsewhere and stay out of the total.
// - Ingress top-of-FIFO counter counts start-of-frame overruns toward destination ports.
// - Multi-port start-of-frame drops add the number of dropping ports.
// - Top, rate, VLAN and DA=SA counters require frames without CRC, align, code error.
// - Rate limit counter counts zero-mask drops from receive or transmit rate limiting.
// - Rate limit counter also counts frames pruned of some expected destinations.
// - VLAN ingress counter counts zero-mask drops when port is not a member.
// - VLAN ingress drops hitting an override entry are not counted.
// - DA=SA counter counts zero-mask drops whose destination equals source address.
// - DA=SA drops count only when the source address is not in the table.
// - Unknown source unicast counter counts error-free data frames of 64 to maximum length.
// - Drop counters consider only address-matched or promiscuous data and control frames.
// - All counters are 32-bit, read-only and zero after reset.
//
// Chosen here: the address map and the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "spds_regs.vh"

module spds_drop_stats (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire [4:0]  rx_flow_ctrl_en,
    input  wire        frm_valid,
    input  wire [2:0]  frm_port,
    input  wire [13:0] frm_len,
    input  wire        frm_is_data,
    input  wire        frm_is_ctrl,
    input  wire        frm_addr_match,
    input  wire        frm_err,
    input  wire        frm_unicast,
    input  wire        frm_pause_sent,
    input  wire        frm_fifo_overrun,
    input  wire [4:0]  forward_port_mask,
    input  wire        rate_limit_drops,
    input  wire        vlan_ingress_drops,
    input  wire        lookup_super_hit,
    input  wire        dest_equals_src_drops,
    input  wire        src_known,
    input  wire        sof_valid,
    input  wire [2:0]  sof_port,
    input  wire [13:0] sof_len,
    input  wire        sof_qualified,
    input  wire        sof_err,
    input  wire [4:0]  sof_drop_mask,
    output reg  [4:0]  unexpected_drop
);

    reg  [31:0] cnt_r [0:`SPDS_NCNT_TOTAL-1];
    reg  [13:0] max_rx_frame_length_r;
    reg  [4:0]  anom_r;
    reg  [4:0]  anom_nxt;

    reg         inc_rx_fifo;
    reg         inc_zero_mask;
    reg         inc_rate;
    reg         inc_vlan;
    reg         inc_da_eq_sa;
    reg         inc_unkn_uni;
    reg  [2:0]  sof_amount;
    reg         frm_qual;
    reg         frm_clean;
    reg         frm_mask_zero;
    reg         frm_port_ok;
    reg         sof_port_ok;
    reg  [5:0]  frm_base;
    reg  [5:0]  sof_idx;

    wire        setup_ph;
    wire        access_done;
    wire [2:0]  rd_port;
    wire [2:0]  rd_sel;
    wire        rd_cnt_hit;
    wire        rd_ctrl_hit;
    wire        rd_stat_hit;
    integer     i;

    function [5:0] spds_cidx;
        input [2:0] port;
        input [2:0] sel;
        reg   [5:0] prod;
        begin
            prod = {3'h0, port} * 6'h07;
            spds_cidx = prod + {3'h0, sel};
        end
    endfunction

    function [2:0] spds_popcount;
        input [4:0] mask;
        integer     k;
        begin
            spds_popcount = 3'h0;
            for (k = 0; k < `SPDS_NPORTS; k = k + 1) begin
                spds_popcount = spds_popcount + {2'h0, mask[k]};
            end
        end
    endfunction

    // Event qualification for the frame report bus.
    always @* begin
        frm_port_ok   = frm_valid && (frm_port <= `SPDS_PORT_LAST);
        frm_qual      = (frm_is_data || frm_is_ctrl) && frm_addr_match;
        frm_clean     = !frm_err;
        frm_mask_zero = (forward_port_mask == 5'h00);
        frm_base      = spds_cidx(frm_port, 3'h0);
        // The host port sees short frames that the Ethernet MACs already call fragments.
        if (frm_port == 3'h0) begin
            inc_rx_fifo = frm_port_ok && frm_qual && frm_fifo_overrun
                          && (frm_len >= `SPDS_HOST_MIN_LEN);
        end else begin
            inc_rx_fifo = frm_port_ok && frm_qual && frm_fifo_overrun
                          && (frm_len >= `SPDS_SHORT_LEN);
        end
        inc_zero_mask = frm_port_ok && frm_qual && frm_mask_zero
                        && (frm_len >= `SPDS_SHORT_LEN);
        inc_rate      = frm_port_ok && frm_qual && frm_clean && rate_limit_drops
                        && (frm_len >= `SPDS_SHORT_LEN);
        inc_vlan      = frm_port_ok && frm_qual && frm_clean && frm_mask_zero
                        && vlan_ingress_drops && !lookup_super_hit
                        && (frm_len >= `SPDS_SHORT_LEN);
        inc_da_eq_sa  = frm_port_ok && frm_qual && frm_clean && frm_mask_zero
                        && dest_equals_src_drops && !src_known
                        && (frm_len >= `SPDS_SHORT_LEN);
        inc_unkn_uni  = frm_port_ok && frm_is_data && frm_addr_match && frm_clean
                        && frm_unicast && !src_known
                        && (frm_len >= `SPDS_UNI_MIN_LEN)
                        && (frm_len <= max_rx_frame_length_r);
        sof_port_ok   = sof_valid && (sof_port <= `SPDS_PORT_LAST);
        sof_idx       = spds_cidx(sof_port, `SPDS_SEL_SOF_OVR);
        if (sof_port_ok && sof_qualified && !sof_err && (sof_len >= `SPDS_SHORT_LEN)) begin
            sof_amount = spds_popcount(sof_drop_mask);
        end else begin
            sof_amount = 3'h0;
        end
    end

    // An Ethernet port overrun without flow control and an ignored pause is flagged.
    always @* begin
        anom_nxt = anom_r;
        if (access_done && pwrite && rd_stat_hit) begin
            anom_nxt = anom_r & ~pwdata[`SPDS_STAT_ANOM_MSB:0];
        end
        if (frm_port_ok && frm_fifo_overrun && (frm_port != 3'h0)
            && !(rx_flow_ctrl_en[frm_port] && frm_pause_sent)) begin
            anom_nxt[frm_port] = 1'b1;
        end
    end

    // Counters only increment and wrap naturally; the two event buses never share a counter.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (i = 0; i < `SPDS_NCNT_TOTAL; i = i + 1) begin
                cnt_r[i] <= `SPDS_CNT_RST;
            end
        end else begin
            if (inc_rx_fifo) begin
                cnt_r[frm_base + {3'h0, `SPDS_SEL_RX_FIFO}] <=
                    cnt_r[frm_base + {3'h0, `SPDS_SEL_RX_FIFO}] + 32'h00000001;
            end
            if (inc_zero_mask) begin
                cnt_r[frm_base + {3'h0, `SPDS_SEL_ZERO_MASK}] <=
                    cnt_r[frm_base + {3'h0, `SPDS_SEL_ZERO_MASK}] + 32'h00000001;
            end
            if (inc_rate) begin
                cnt_r[frm_base + {3'h0, `SPDS_SEL_RATE_LIM}] <=
                    cnt_r[frm_base + {3'h0, `SPDS_SEL_RATE_LIM}] + 32'h00000001;
            end
            if (inc_vlan) begin
                cnt_r[frm_base + {3'h0, `SPDS_SEL_VLAN_ING}] <=
                    cnt_r[frm_base + {3'h0, `SPDS_SEL_VLAN_ING}] + 32'h00000001;
            end
            if (inc_da_eq_sa) begin
                cnt_r[frm_base + {3'h0, `SPDS_SEL_DA_EQ_SA}] <=
                    cnt_r[frm_base + {3'h0, `SPDS_SEL_DA_EQ_SA}] + 32'h00000001;
            end
            if (inc_unkn_uni) begin
                cnt_r[frm_base + {3'h0, `SPDS_SEL_UNKN_UNI}] <=
                    cnt_r[frm_base + {3'h0, `SPDS_SEL_UNKN_UNI}] + 32'h00000001;
            end
            if (sof_amount != 3'h0) begin
                cnt_r[sof_idx] <= cnt_r[sof_idx] + {29'h0, sof_amount};
            end
        end
    end

    // APB slave: one access cycle, answer registered at the end of setup.
    assign setup_ph    = psel && !penable;
    assign access_done = psel && penable && pready;
    assign rd_port     = paddr[`SPDS_PORT_MSB:`SPDS_PORT_LSB];
    assign rd_sel      = paddr[`SPDS_SEL_MSB:`SPDS_SEL_LSB];
    assign rd_cnt_hit  = (paddr[11:8] == `SPDS_CNT_REGION) && (paddr[1:0] == 2'h0)
                         && (rd_port <= `SPDS_PORT_LAST) && (rd_sel <= `SPDS_SEL_LAST);
    assign rd_ctrl_hit = (paddr == `SPDS_CTRL_OFS);
    assign rd_stat_hit = (paddr == `SPDS_STAT_OFS);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata                <= 32'h00000000;
            pready                <= 1'b0;
            pslverr               <= 1'b0;
            max_rx_frame_length_r <= `SPDS_MAXLEN_RST;
            anom_r                <= `SPDS_STAT_RST;
            unexpected_drop       <= `SPDS_STAT_RST;
        end else begin
            anom_r          <= anom_nxt;
            unexpected_drop <= anom_nxt;
            pready          <= setup_ph;
            if (setup_ph) begin
                pslverr <= !(rd_cnt_hit || rd_ctrl_hit || rd_stat_hit);
                if (pwrite) begin
                    prdata <= 32'h00000000;
                end else if (rd_cnt_hit) begin
                    prdata <= cnt_r[spds_cidx(rd_port, rd_sel)];
                end else if (rd_ctrl_hit) begin
                    prdata <= {18'h0, max_rx_frame_length_r};
                end else if (rd_stat_hit) begin
                    prdata <= {27'h0, anom_r};
                end else begin
                    prdata <= 32'h00000000;
                end
            end else begin
                pslverr <= 1'b0;
            end
            // Writes to the counters are ignored without error: they are read-only.
            if (access_done && pwrite && rd_ctrl_hit) begin
                max_rx_frame_length_r <= pwdata[`SPDS_CTRL_MAXLEN_MSB:0];
            end
        end
    end

endmodule // spds_drop_stats
`default_nettype wire

/* File: testbench/spds_drop_stats_asserts.sv */
// Assertion checker bound to the ports of the drop statistics block.
`timescale 1ns/100ps
`default_nettype none
module spds_drop_stats_asserts (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [4:0]  rx_flow_ctrl_en,
    input wire logic        frm_valid,
    input wire logic [2:0]  frm_port,
    input wire logic [13:0] frm_len,
    input wire logic        frm_is_data,
    input wire logic        frm_is_ctrl,
    input wire logic        frm_addr_match,
    input wire logic        frm_pause_sent,
    input wire logic        frm_fifo_overrun,
    input wire logic [4:0]  unexpected_drop
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic stat_wr_r;
    logic stat_wr_q;
    wire  any_flag = |unexpected_drop;
    wire  setup    = psel && !penable;
    // Two stages of the status write strobe; the flag output updates in the same cycle as the status register.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_wr_r <= 1'b0;
            stat_wr_q <= 1'b0;
        end else begin
            stat_wr_r <= psel && penable && pwrite && paddr == 12'h104;
            stat_wr_q <= stat_wr_r;
        end
    end
    property p_ready_next; setup |=> pready; endproperty
    a_ready_next: assert property (p_ready_next) else $error("no ready after setup");
    property p_ready_pulse; pready |=> !pready; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");
    property p_ready_acc; pready |-> psel && penable; endproperty
    a_ready_acc: assert property (p_ready_acc) else $error("ready outside access");
    property p_cnt_ok; setup && paddr < 12'h0A0 && paddr[4:2] != 3'h7 |=> !pslverr; endproperty
    a_cnt_ok: assert property (p_cnt_ok) else $error("error on counter");
    property p_gap_err; setup && paddr < 12'h0A0 && paddr[4:2] == 3'h7 |=> pslverr && prdata == 32'h0; endproperty
    a_gap_err: assert property (p_gap_err) else $error("gap not refused");
    property p_hi_err; setup && paddr >= 12'h108 |=> pslverr && prdata == 32'h0; endproperty
    a_hi_err: assert property (p_hi_err) else $error("high address not refused");
    property p_flag_set;
        frm_valid && frm_fifo_overrun && (frm_is_data || frm_is_ctrl) && frm_addr_match
        && frm_port != 3'h0 && frm_port <= 3'h4 && frm_len >= 14'h0021
        && !(rx_flow_ctrl_en[frm_port] && frm_pause_sent) |-> ##[1:2] any_flag;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("unexpected drop not flagged");
    property p_flag_hold; $fell(any_flag) |-> stat_wr_r || stat_wr_q; endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag lost without clear");
endmodule // spds_drop_stats_asserts
bind spds_drop_stats spds_drop_stats_asserts chk_u (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .prdata, .pready, .pslverr, .rx_flow_ctrl_en, .frm_valid, .frm_port, .frm_len,
    .frm_is_data, .frm_is_ctrl, .frm_addr_match, .frm_pause_sent, .frm_fifo_overrun,
    .unexpected_drop);
`default_nettype wire

/* File: testbench/spds_drop_stats_tb.sv */
// Self-checking testbench of the drop statistics block.
`timescale 1ns/100ps
`default_nettype none
`include "spds_regs.vh"
module spds_drop_stats_tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, frm_valid, sof_valid, sq;
    logic [11:0] paddr, fl;
    logic [31:0] pwdata, prdata, q;
    logic        e;
    logic [2:0]  frm_port;
    logic [13:0] frm_len;
    logic [4:0]  rx_flow_ctrl_en, forward_port_mask, sof_drop_mask, unexpected_drop;
    logic [31:0] exp_cnt [5][7];
    logic [4:0]  exp_flag;
    int          fails, n_compared;
    spds_drop_stats dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .rx_flow_ctrl_en, .frm_valid, .frm_port, .frm_len,
        .frm_is_data(fl[0]), .frm_is_ctrl(fl[1]), .frm_addr_match(fl[2]), .frm_err(fl[3]),
        .frm_unicast(fl[4]), .frm_pause_sent(fl[5]), .frm_fifo_overrun(fl[6]),
        .forward_port_mask, .rate_limit_drops(fl[7]), .vlan_ingress_drops(fl[8]),
        .lookup_super_hit(fl[9]), .dest_equals_src_drops(fl[10]), .src_known(fl[11]),
        .sof_valid, .sof_port(frm_port), .sof_len(frm_len), .sof_qualified(sq),
        .sof_err(fl[3]), .sof_drop_mask, .unexpected_drop);
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] want);
        n_compared++;
        if (seen !== want) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, want, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge pclk);
        end
        // A slave that never answers counts as a mismatch rather than a silent pass.
        if (n >= 50) fails++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic chk_all();
        for (int p = 0; p < 5; p++)
            for (int s = 0; s < 7; s++) begin
                apb(1'b0, 12'(p * 32 + s * 4), 32'h0);
                chk($sformatf("cnt_%0d_%0d", p, s), q, exp_cnt[p][s]);
                chk("cnt_err", {31'h0, e}, 32'h0);
            end
    endtask
    // Counters only move for ports 0 to 4; the same fields feed both event buses.
    task automatic ev(input logic [2:0] p, input logic [13:0] l, input logic [11:0] f,
                      input logic [4:0] m, input logic [4:0] sm);
        logic qu;
        logic ok;
        logic [4:0] fc;
        qu = (f[0] | f[1]) & f[2];
        fc = 5'($urandom);
        if (p != 3'h0 && p < 3'h5 && f[6] && !(fc[p] && f[5])) exp_flag[p] = 1'b1;
        ok = qu & !f[3] & l >= 14'h0021;
        frm_valid <= 1'b1;
        sof_valid <= 1'b1;
        frm_port <= p;
        frm_len <= l;
        fl <= f;
        forward_port_mask <= m;
        sof_drop_mask <= sm;
        sq <= qu;
        rx_flow_ctrl_en <= fc;
        if (p < 3'h5) begin
            exp_cnt[p][0] += qu & f[6] & l >= (p == 3'h0 ? 14'h0011 : 14'h0021);
            exp_cnt[p][1] += qu & m == 5'h00 & l >= 14'h0021;
            exp_cnt[p][2] += ok ? $countones(sm) : 0;
            exp_cnt[p][3] += ok & f[7];
            exp_cnt[p][4] += ok & m == 5'h00 & f[8] & !f[9];
            exp_cnt[p][5] += ok & m == 5'h00 & f[10] & !f[11];
            exp_cnt[p][6] += f[0] & f[2] & !f[3] & f[4] & !f[11] & l >= 14'h0040 & l <= `SPDS_MAXLEN_RST;
        end
        @(posedge pclk);
    endtask
    function automatic logic [13:0] pick_len();
        logic [13:0] lens [8] = '{14'h0010, 14'h0011, 14'h0020, 14'h0021, 14'h003F, 14'h0040,
                                  14'h05EE, 14'h05EF};
        return ($urandom % 2) ? lens[$urandom % 8] : 14'($urandom % 2000);
    endfunction
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        stop_test();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, frm_valid, sof_valid, sq} = '0;
        {frm_port, frm_len, fl, rx_flow_ctrl_en, forward_port_mask, sof_drop_mask} = '0;
        foreach (exp_cnt[i, j]) exp_cnt[i][j] = 32'h0;
        exp_flag = 5'h00;
        fails = 0;
        n_compared = 0;
        void'($urandom(31698));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk_all();
        apb(1'b0, 12'h100, 32'h0);
        chk("max_len", q, {18'h0, `SPDS_MAXLEN_RST});
        apb(1'b1, 12'h024, $urandom);
        chk("ro_write_err", {31'h0, e}, 32'h0);
        $display("test reset_and_access done");
        ev(3'h0, 14'h0011, 12'h045, 5'h01, 5'h00);
        ev(3'h0, 14'h0010, 12'h045, 5'h01, 5'h00);
        ev(3'h1, 14'h0020, 12'h045, 5'h00, 5'h00);
        ev(3'h2, 14'h0021, 12'h005, 5'h00, 5'h1F);
        ev(3'h5, 14'h0040, 12'h7FF, 5'h00, 5'h1F);
        repeat (400) ev(3'($urandom % 6), pick_len(), 12'($urandom),
                        5'($urandom % 2 ? 0 : $urandom), 5'($urandom));
        frm_valid <= 1'b0;
        sof_valid <= 1'b0;
        @(posedge pclk);
        chk_all();
        $display("test event_counting done");
        chk("flag_out", {27'h0, unexpected_drop}, {27'h0, exp_flag});
        apb(1'b0, 12'h104, 32'h0);
        chk("flag_reg", q, {27'h0, exp_flag});
        apb(1'b1, 12'h104, 32'h0000001F);
        apb(1'b0, 12'h104, 32'h0);
        chk("flag_clr", q, 32'h0);
        chk("flag_out_clr", {27'h0, unexpected_drop}, 32'h0);
        apb(1'b1, 12'h100, 32'h00000100);
        apb(1'b0, 12'h100, 32'h0);
        chk("max_len_wr", q, 32'h00000100);
        apb(1'b0, 12'h01C, 32'h0);
        chk("gap_err", {31'h0, e}, 32'h1);
        apb(1'b0, 12'h108, 32'h0);
        chk("high_data", q, 32'h0);
        chk("high_err", {31'h0, e}, 32'h1);
        $display("test refusals done");
        stop_test();
    end
endmodule // spds_drop_stats_tb
`default_nettype wire
